// File: hw/apc_pin_config.sv
// Per-pin analog or digital selection for up to 32 converter input pins.
// Assumes synchronous inputs on clk; pin presence is given by a parameter mask.
//
// The strobed register port and the register offsets were left to the implementer.
`timescale 1ns/1ps

// Operation
// - Select bit 1: pin digital, read buffer on, converter channel tied to analog ground
// - Select bit 0: pin analog, read buffer off, converter samples the pin
// - High register bit n governs analog input 16+n
// - Low register bit n governs analog input n
// - All select bits read and write; bits of absent pins affect nothing
// - Second converter has low register only, inputs 0 through 15
// - Both converters' low registers influence shared pins 0 through 15
// - Module disable makes a converter count as asking digital; shared pins are forced digital only when every fitted converter is disabled
// - All select bits clear at reset, so pins start analog
module apc_pin_config #(
   parameter logic [31:0] PIN_PRESENT = apc_pkg::PRESENT_ALL, // Pins that exist on this part
   parameter logic DUAL_CONVERTER = 1'b1 // Second converter fitted
) (
   input wire logic clk, // 40 MHz system clock
   input wire logic reset, // Asynchronous reset, active high
   input wire logic [apc_pkg::ADDR_W-1:0] reg_addr, // Register index
   input wire logic [apc_pkg::DATA_W-1:0] reg_wdata, // Write data
   input wire logic reg_wr, // Write strobe
   input wire logic reg_rd, // Read strobe
   output logic [apc_pkg::DATA_W-1:0] reg_rdata, // Read data, cycle after strobe
   output logic [apc_pkg::NUM_INPUTS-1:0] digital_read_enable, // Pin input buffer on
   output logic [apc_pkg::NUM_INPUTS-1:0] analog_ground_tie, // Mux channel tied to ground
   output logic [apc_pkg::NUM_INPUTS-1:0] analog_sample_enable // Converter samples pin
);
   // ****************************************
   // Registers
   // ****************************************
   logic [15:0] sel_low1_ff;
   logic [15:0] sel_high1_ff;
   logic [15:0] sel_low2_ff;
   logic [1:0] ctrl_ff;
   logic [15:0] reg_rdata_ff;
   logic [31:0] dig_ff;
   logic [31:0] gnd_ff;
   logic [31:0] smp_ff;

   // Decode of the write port
   wire logic wr_low1 = reg_wr && (reg_addr == apc_pkg::OFS_SEL_LOW1);
   wire logic wr_high1 = reg_wr && (reg_addr == apc_pkg::OFS_SEL_HIGH1);
   wire logic wr_low2 = reg_wr && (reg_addr == apc_pkg::OFS_SEL_LOW2);
   wire logic wr_ctrl = reg_wr && (reg_addr == apc_pkg::OFS_CTRL);

   // Disable bits; the second converter's bit counts only when it is fitted
   wire logic dis1 = ctrl_ff[apc_pkg::CTRL_DIS1_BIT];
   wire logic dis2 = ctrl_ff[apc_pkg::CTRL_DIS2_BIT] && DUAL_CONVERTER;

   // Per-pin digital request from the select bits
   logic [31:0] pin_digital;
   logic [31:0] nxt_dig;
   logic [31:0] nxt_gnd;
   logic [31:0] nxt_smp;

   genvar gi;
   generate
      for (gi = 0; gi < apc_pkg::NUM_INPUTS; gi++) begin : g_pin
         if (gi < apc_pkg::LOW_INPUTS) begin : g_low
            // Shared pin: analog if either enabled converter asks for analog
            wire logic want1 = sel_low1_ff[gi] || dis1;
            wire logic want2 = sel_low2_ff[gi] || dis2 || !DUAL_CONVERTER;
            assign pin_digital[gi] = want1 && want2;
         end else begin : g_high
            assign pin_digital[gi] = sel_high1_ff[gi-apc_pkg::LOW_INPUTS] || dis1;
         end
         // Absent pins stay quiet whatever the select bit holds
         assign nxt_dig[gi] = PIN_PRESENT[gi] && pin_digital[gi];
         assign nxt_gnd[gi] = PIN_PRESENT[gi] && pin_digital[gi];
         assign nxt_smp[gi] = PIN_PRESENT[gi] && !pin_digital[gi];
      end
   endgenerate

   // Read mux; unmapped indices read zero, reads have no side effect
   logic [15:0] nxt_reg_rdata;
   always_comb begin
      case (reg_addr)
         apc_pkg::OFS_SEL_LOW1: nxt_reg_rdata = sel_low1_ff;
         apc_pkg::OFS_SEL_HIGH1: nxt_reg_rdata = sel_high1_ff;
         apc_pkg::OFS_SEL_LOW2: nxt_reg_rdata = DUAL_CONVERTER ? sel_low2_ff : apc_pkg::RD_ZERO;
         apc_pkg::OFS_CTRL: nxt_reg_rdata = {14'h0000, ctrl_ff};
         apc_pkg::OFS_PIN_MODE_LO: nxt_reg_rdata = dig_ff[15:0];
         apc_pkg::OFS_PIN_MODE_HI: nxt_reg_rdata = dig_ff[31:16];
         default: nxt_reg_rdata = apc_pkg::RD_ZERO;
      endcase
   end

   // ****************************************
   // Select and control registers
   // ****************************************
   // Writes land on the edge with the strobe; pins follow one edge later
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         sel_low1_ff <= apc_pkg::SEL_RESET;
         sel_high1_ff <= apc_pkg::SEL_RESET;
         sel_low2_ff <= apc_pkg::SEL_RESET;
         ctrl_ff <= apc_pkg::CTRL_RESET;
      end else begin
         if (wr_low1) begin
            sel_low1_ff <= reg_wdata;
         end
         if (wr_high1) begin
            sel_high1_ff <= reg_wdata;
         end
         if (wr_low2 && DUAL_CONVERTER) begin
            sel_low2_ff <= reg_wdata;
         end
         if (wr_ctrl) begin
            ctrl_ff <= reg_wdata[1:0];
         end
      end
   end

   // Pin outputs registered so the pads never see decode glitches; reset leaves all analog
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         dig_ff <= 32'h00000000;
         gnd_ff <= 32'h00000000;
         smp_ff <= PIN_PRESENT;
         reg_rdata_ff <= apc_pkg::RD_ZERO;
      end else begin
         dig_ff <= nxt_dig;
         gnd_ff <= nxt_gnd;
         smp_ff <= nxt_smp;
         reg_rdata_ff <= reg_rd ? nxt_reg_rdata : apc_pkg::RD_ZERO;
      end
   end

   assign reg_rdata = reg_rdata_ff;
   assign digital_read_enable = dig_ff;
   assign analog_ground_tie = gnd_ff;
   assign analog_sample_enable = smp_ff;
endmodule // apc_pin_config

// File: include/apc_pkg.sv
// Package for the analog pin port configuration block.
// Assumes a plain register port: address, write data, strobes, read data a cycle later.
package apc_pkg;
   // ****************************************
   // Register map and widths
   // ****************************************
   localparam int unsigned ADDR_W = 4;
   localparam int unsigned DATA_W = 16;
   localparam int unsigned NUM_INPUTS = 32;
   localparam int unsigned LOW_INPUTS = 16;
   localparam logic [3:0] OFS_SEL_LOW1 = 4'h0;  // Low select, first converter
   localparam logic [3:0] OFS_SEL_HIGH1 = 4'h1; // High select, first converter
   localparam logic [3:0] OFS_SEL_LOW2 = 4'h2;  // Low select, second converter
   localparam logic [3:0] OFS_CTRL = 4'h3;      // Module disable bits
   localparam logic [3:0] OFS_PIN_MODE_LO = 4'h4; // Effective mode, inputs 0-15
   localparam logic [3:0] OFS_PIN_MODE_HI = 4'h5; // Effective mode, inputs 16-31
   // ****************************************
   // Fields and reset values
   // ****************************************
   localparam int unsigned CTRL_DIS1_BIT = 0;
   localparam int unsigned CTRL_DIS2_BIT = 1;
   localparam logic [15:0] SEL_RESET = 16'h0000;
   localparam logic [1:0] CTRL_RESET = 2'h0;
   localparam logic [15:0] RD_ZERO = 16'h0000;
   localparam logic [31:0] PRESENT_ALL = 32'hFFFFFFFF;
endpackage

// File: bench/apc_pin_model.sv
// Far side: what the converter and a port read see of each pin.
// Assumes the block's pin controls drive it directly.
`timescale 1ns/1ps
module apc_pin_model (
   input wire logic [31:0] pin, se, de, // Pin level, sample and buffer enables
   output logic [31:0] cv, pv // Converter input, port read value
);
   // An off buffer floats; shown inverted so a wrong enable cannot pass
   assign cv = pin & se;
   assign pv = ~(pin ^ de);
endmodule // apc_pin_model

// File: bench/apc_pin_config_chk.sv
// Assertions on the pin configuration ports.
// Assumes default parameters: all pins present, two converters.
`timescale 1ns/1ps
module apc_pin_config_chk (
   input wire logic clk, reset, reg_wr, reg_rd, // Clock, reset, strobes
   input wire logic [3:0] reg_addr, // Index
   input wire logic [15:0] reg_wdata, reg_rdata, // Data
   input wire logic [31:0] digital_read_enable, analog_sample_enable // Pins
);
   wire [31:0] de = digital_read_enable;
   logic [16:0] m_ff; // Disable 1 and low select 1 as written
   default clocking @(posedge clk); endclocking
   default disable iff (reset);
   // Mirror kept so pin checks need no model of the body
   always_ff @(posedge clk or posedge reset)
      if (reset) m_ff <= 17'h00000;
      else if (reg_wr && reg_addr == 4'h0) m_ff[15:0] <= reg_wdata;
      else if (reg_wr && reg_addr == 4'h3) m_ff[16] <= reg_wdata[0];
   sequence s_wr_rd; reg_wr && reg_addr < 4'h3 ##1 reg_rd && reg_addr == $past(reg_addr); endsequence
   sequence s_wr_hi; reg_wr && reg_addr == 4'h1 ##1 !(reg_wr && reg_addr == 4'h3); endsequence
   AST_EXCL: assert property ((de ^ analog_sample_enable) == '1) else $error("use");
   AST_IDLE: assert property (!reg_rd |=> reg_rdata == 16'h0000) else $error("idle");
   AST_BACK: assert property (s_wr_rd |=> reg_rdata == $past(reg_wdata, 2)) else $error("rd");
   AST_HIGH: assert property (s_wr_hi |=> de[31:16] == ($past(reg_wdata, 2) | {16{m_ff[16]}}))
      else $error("high");
   AST_DIS: assert property ($stable(m_ff) && m_ff[16] |-> de[31:16] == 16'hFFFF) else $error("dis");
   AST_AND: assert property ($stable(m_ff) |-> (de[15:0] & ~(m_ff[15:0] | {16{m_ff[16]}})) == 0)
      else $error("low");
   AST_RST: assert property (disable iff (1'b0) reset |-> de == 32'h0) else $error("rst");
   AST_QUIET: assert property (reg_rd && !$past(reg_wr) |=> $stable(de)) else $error("side");
endmodule // apc_pin_config_chk
bind apc_pin_config apc_pin_config_chk i_chk (.clk(clk), .reset(reset), .reg_wr(reg_wr),
   .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
   .digital_read_enable(digital_read_enable), .analog_sample_enable(analog_sample_enable));

// File: bench/apc_pin_config_tb_top.sv
// Bench top: random select traffic, pin map and far side checks.
// Assumes default block parameters.
`timescale 1ns/1ps
module apc_pin_config_tb_top;
   logic clk, reset, reg_wr, reg_rd;
   logic [3:0] reg_addr;
   logic [15:0] reg_wdata, reg_rdata, r [6];
   logic [31:0] de, gt, se, pin, cv, pv, rnd;
   int num_errors, checks_done;
   apc_pin_config i_dut (.clk(clk), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .digital_read_enable(de),
      .analog_ground_tie(gt), .analog_sample_enable(se));
   apc_pin_model i_far (.pin(pin), .se(se), .de(de), .cv(cv), .pv(pv));
   function automatic logic [31:0] lfsr(logic [31:0] x);
      return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
   endfunction
   // Shared pins go digital only when each converter wants it or is disabled
   function automatic logic [31:0] want(logic [15:0] l1, h, l2, c);
      return {h | {16{c[0]}}, (l1 | {16{c[0]}}) & (l2 | {16{c[1]}})};
   endfunction
   task automatic chk(logic [63:0] seen, exp, string what);
      checks_done++;
      if (seen !== exp) begin
         num_errors++;
         $display("mismatch %s expected %h seen %h", what, exp, seen);
      end
   endtask
   // Write strobe stays up until the next call moves it, so writes run back to back
   task automatic wr(logic [3:0] a, logic [15:0] d);
      @(posedge clk) {reg_wr, reg_rd, reg_addr, reg_wdata} <= {2'b10, a, d};
   endtask
   task automatic rd(logic [3:0] a, logic [15:0] e);
      @(posedge clk) {reg_wr, reg_rd, reg_addr} <= {2'b01, a};
      @(posedge clk) reg_rd <= 1'b0;
      #1 chk(reg_rdata, e, "read data");
   endtask
   task automatic wrap_up;
      $display("checks %0d errors %0d", checks_done, num_errors);
      if (num_errors == 0 && checks_done > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask
   initial forever #12.5 clk = ~clk;
   // Reset values first; round 0 sets every select bit with control clear, round 1 disables both converters
   initial begin
      {clk, reset, reg_wr, reg_rd, reg_addr, reg_wdata, pin, num_errors, checks_done} = '0;
      #1 reset = 1'b1; // Raised after time zero so every reset process sees the edge
      rnd = 32'h60B81485;
      repeat (4) @(posedge clk);
      reset <= 1'b0;
      for (int j = 0; j < 7; j++) rd(j[3:0], 16'h0000);
      for (int k = 0; k < 24; k++) begin
         rnd = lfsr(lfsr(lfsr(rnd)));
         {r[1], r[0]} = (k == 0) ? 32'hFFFFFFFF : rnd;
         r[2] = (k == 0) ? 16'hFFFF : ~rnd[23:8];
         r[3] = {14'h0, (k == 1) ? 2'h3 : (k == 0) ? 2'h0 : rnd[13:12]};
         {r[5], r[4]} = want(r[0], r[1], r[2], r[3]);
         pin <= {rnd[15:0], rnd[31:16]};
         for (int j = 3; j >= 0; j--) wr(j[3:0], r[j]);
         for (int j = 0; j < 6; j++) rd(j[3:0], r[j]);
         chk(de, {r[5], r[4]}, "read enable");
         chk({gt, se}, {r[5], r[4], ~r[5], ~r[4]}, "tie and sample");
         chk(cv | (pv & {r[5], r[4]}), pin, "far side");
      end
      wrap_up();
   end
endmodule // apc_pin_config_tb_top
